// [verilog/bit_pkg.sv]
// package for the basic interval timer: register map, field layout, prescale codes
// assumes a 32-bit axi4-lite register bus and a single 100 MHz clock
package bit_pkg;

	// ==========================================================
	// register map (byte addresses, printed offsets are not word aligned)
	localparam int          REG_ADDR_W       = 12;
	localparam int          TIMER_MODE_IDX   = 'hd8;
	localparam int          TIMER_COUNT_IDX  = 'hd9;
	localparam int          IRQ_STATUS_IDX   = 'hda;
	localparam int          IRQ_MASK_IDX     = 'hdb;
	localparam logic [11:0] TIMER_MODE_ADDR  = 12'(TIMER_MODE_IDX * 4);
	localparam logic [11:0] TIMER_COUNT_ADDR = 12'(TIMER_COUNT_IDX * 4);
	localparam logic [11:0] IRQ_STATUS_ADDR  = 12'(IRQ_STATUS_IDX * 4);
	localparam logic [11:0] IRQ_MASK_ADDR    = 12'(IRQ_MASK_IDX * 4);

	// ==========================================================
	// fields and reset values
	localparam int         RUN_BIT        = 7;
	localparam int         RATE_LSB       = 4;
	localparam int         RATE_W         = 3;
	localparam int         COUNT_MSB      = 7;
	localparam int         STAT_OVF_BIT   = 0;
	localparam logic [7:0] MODE_WR_MASK   = 8'hf0;
	localparam logic [7:0] MODE_RESET     = 8'h00;
	localparam logic [7:0] COUNT_RESET    = 8'h00;
	localparam logic [7:0] COUNT_ONE      = 8'h01;
	localparam logic [0:0] IRQ_RESET      = 1'h0;
	localparam logic [7:0] PRESC_RESET    = 8'h00;
	localparam logic [7:0] PRESC_ONE      = 8'h01;

	// ==========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	// ==========================================================
	// clock period in nanoseconds
	localparam int CLK_PERIOD_NS = 10;

	typedef struct packed {
		logic       run;
		logic [2:0] rate;
	} bit_mode_s;

endpackage

// [verilog/bit_timer.sv]
// basic 8-bit interval timer with prescaler, overflow flag, mask and irq
// assumes an axi4-lite master on aclk; the cpu clock here is aclk itself
`timescale 1ns/100ps

// Overview of operation
// - mode bits 6..4 pick clock divide 256 (000) down to 2 (111).
// - mode bit 7 runs the counter when 1, stops it when 0; reset 0.
// - count register is 8-bit read/write, cleared at reset.
// - counter steps once per prescaled tick, wraps ff to 00 and flags overflow.
// - flag sets on any count bit 7 fall, running or not, writes included.
// - a pending flag raises the irq the cycle after its mask enables it.
// - overflow while running pulses a wake output for the low-power mode.
module bit_timer (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// system
	output logic             irq,
	output logic             wake
);

	// ==========================================================
	// state
	bit_pkg::bit_mode_s mode_reg,   mode_next;
	logic [7:0]         count_reg,  count_next;
	logic [7:0]         presc_reg,  presc_next;
	logic               stat_reg,   stat_next;
	logic               mask_reg,   mask_next;
	logic               irq_reg,    irq_next;
	logic               wake_reg,   wake_next;
	logic               awok_reg,   awok_next;
	logic [11:0]        awaddr_reg, awaddr_next;
	logic               wok_reg,    wok_next;
	logic [31:0]        wdata_reg,  wdata_next;
	logic [3:0]         wstrb_reg,  wstrb_next;
	logic               bvalid_reg, bvalid_next;
	logic [1:0]         bresp_reg,  bresp_next;
	logic               rvalid_reg, rvalid_next;
	logic [31:0]        rdata_reg,  rdata_next;
	logic [1:0]         rresp_reg,  rresp_next;

	// divide ratio minus one for a rate code: 000 -> 255, 111 -> 1
	function automatic logic [7:0] rate_limit(input logic [2:0] rate);
		rate_limit = 8'((16'h0100 >> rate) - 16'h0001);
	endfunction

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == bit_pkg::TIMER_MODE_ADDR) || (a == bit_pkg::TIMER_COUNT_ADDR) ||
		             (a == bit_pkg::IRQ_STATUS_ADDR) || (a == bit_pkg::IRQ_MASK_ADDR);
	endfunction

	// ==========================================================
	// write path
	logic        do_write;
	logic        lane0;
	logic [7:0]  wbyte;
	logic        tick;
	logic        ovf;

	// a write with wstrb[0] low is answered but changes nothing
	// unmapped addresses answer slverr and change nothing
	always_comb begin
		awok_next   = awok_reg;
		awaddr_next = awaddr_reg;
		wok_next    = wok_reg;
		wdata_next  = wdata_reg;
		wstrb_next  = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		if (s_axi_awvalid && !awok_reg) begin
			awok_next   = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wok_reg) begin
			wok_next   = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		// address and data held until both are in, then one response
		do_write = awok_reg && wok_reg && !bvalid_reg;
		if (do_write) begin
			awok_next   = 1'b0;
			wok_next    = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = addr_known(awaddr_reg) ? bit_pkg::RESP_OKAY : bit_pkg::RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end

	// ==========================================================
	// prescaler, counter, flag
	always_comb begin
		lane0      = do_write && wstrb_reg[0];
		wbyte      = wdata_reg[7:0];
		mode_next  = mode_reg;
		count_next = count_reg;
		presc_next = presc_reg;
		mask_next  = mask_reg;
		tick       = 1'b0;
		if (mode_reg.run) begin
			if (presc_reg >= rate_limit(mode_reg.rate)) begin
				presc_next = bit_pkg::PRESC_RESET;
				tick       = 1'b1;
			end else begin
				presc_next = presc_reg + bit_pkg::PRESC_ONE;
			end
		end else begin
			// stopped timer restarts a fresh step
			presc_next = bit_pkg::PRESC_RESET;
		end
		// step once per tick, wrap over 256 steps
		if (tick) begin
			count_next = count_reg + bit_pkg::COUNT_ONE;
		end
		// software write wins over the step
		if (lane0 && awaddr_reg == bit_pkg::TIMER_COUNT_ADDR) begin
			count_next = wbyte;
		end
		// run bit and rate, low nibble unimplemented
		if (lane0 && awaddr_reg == bit_pkg::TIMER_MODE_ADDR) begin
			mode_next.run  = wbyte[bit_pkg::RUN_BIT];
			mode_next.rate = wbyte[bit_pkg::RATE_LSB +: bit_pkg::RATE_W];
		end
		if (lane0 && awaddr_reg == bit_pkg::IRQ_MASK_ADDR) begin
			mask_next = wbyte[bit_pkg::STAT_OVF_BIT];
		end
		// any fall of bit 7, write or count
		ovf = count_reg[bit_pkg::COUNT_MSB] && !count_next[bit_pkg::COUNT_MSB];
		// set wins over a write-one clear in the same cycle
		stat_next = stat_reg;
		if (lane0 && awaddr_reg == bit_pkg::IRQ_STATUS_ADDR && wbyte[bit_pkg::STAT_OVF_BIT]) begin
			stat_next = 1'b0;
		end
		if (ovf) begin
			stat_next = 1'b1;
		end
		// pending flag shows one cycle after enable
		irq_next  = stat_reg && mask_reg;
		// wake pulse on overflow while running
		wake_next = ovf && mode_reg.run;
	end

	// ==========================================================
	// read path
	logic [7:0] rbyte;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		// registers read back in the low byte, upper bits zero
		// reads have no side effects, so a repeated read is harmless
		unique case (s_axi_araddr)
			bit_pkg::TIMER_MODE_ADDR:  rbyte = {mode_reg.run, mode_reg.rate, 4'h0};
			bit_pkg::TIMER_COUNT_ADDR: rbyte = count_reg;
			bit_pkg::IRQ_STATUS_ADDR:  rbyte = {7'h00, stat_reg};
			bit_pkg::IRQ_MASK_ADDR:    rbyte = {7'h00, mask_reg};
			default:                   rbyte = 8'h00;
		endcase
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next  = {24'h000000, rbyte};
			rresp_next  = addr_known(s_axi_araddr) ? bit_pkg::RESP_OKAY : bit_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// ==========================================================
	// registers
	// one synchronous reset for all state; outputs come from these flops
	// irq drops a cycle after the flag or its enable clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg   <= '{run: 1'b0, rate: 3'h0};
			count_reg  <= bit_pkg::COUNT_RESET;
			presc_reg  <= bit_pkg::PRESC_RESET;
			stat_reg   <= bit_pkg::IRQ_RESET;
			mask_reg   <= bit_pkg::IRQ_RESET;
			irq_reg    <= 1'b0;
			wake_reg   <= 1'b0;
			awok_reg   <= 1'b0;
			awaddr_reg <= 12'h000;
			wok_reg    <= 1'b0;
			wdata_reg  <= 32'h00000000;
			wstrb_reg  <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= bit_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= bit_pkg::RESP_OKAY;
		end else begin
			mode_reg   <= mode_next;
			count_reg  <= count_next;
			presc_reg  <= presc_next;
			stat_reg   <= stat_next;
			mask_reg   <= mask_next;
			irq_reg    <= irq_next;
			wake_reg   <= wake_next;
			awok_reg   <= awok_next;
			awaddr_reg <= awaddr_next;
			wok_reg    <= wok_next;
			wdata_reg  <= wdata_next;
			wstrb_reg  <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// ready is high while the holding slot is empty, so each beat is taken once
	assign s_axi_awready = !awok_reg;
	assign s_axi_wready  = !wok_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign irq           = irq_reg;
	assign wake          = wake_reg;

endmodule

// [bench/bit_timer_properties.sv]
// checker for the interval timer: bus handshakes, reset state, wake pulse
// assumes it is bound to bit_timer and sees its ports under the same names
`timescale 1ns/100ps
module bit_timer_properties (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// system
	input wire logic        irq,
	input wire logic        wake
);
	// ==========================================================
	// properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_wresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
	a_wresp: assert property (p_wresp) else $error("write response late");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rdata; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("read answer wrong");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblk: assert property (p_arblk) else $error("read taken while busy");
	property p_awblk; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_awblk: assert property (p_awblk) else $error("address taken twice");
	property p_wake; wake |=> !wake; endproperty
	a_wake: assert property (p_wake) else $error("wake longer than a cycle");
	// reset must be watched while it is asserted
	property p_rst; disable iff (1'b0) !aresetn |=> !irq && !wake && !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind bit_timer bit_timer_properties i_props (.*);

// [bench/tb_basic_8bit_interval_timer.sv]
// self-checking bench for the interval timer, driven over axi4-lite
// assumes bit_timer and its checker; expected counts come from the bench model
`timescale 1ns/100ps
module tb_basic_8bit_interval_timer;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wake;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	int          bad_count, check_count, i, c, n, w0;
	int          wakes = 0;
	localparam logic [11:0] MA = bit_pkg::TIMER_MODE_ADDR;
	localparam logic [11:0] CA = bit_pkg::TIMER_COUNT_ADDR;
	localparam logic [11:0] SA = bit_pkg::IRQ_STATUS_ADDR;
	localparam logic [11:0] KA = bit_pkg::IRQ_MASK_ADDR;
	bit_timer i_dut (.*);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) if (wake === 1'b1) wakes <= wakes + 1;
	// ==========================================================
	// reporting
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ==========================================================
	// bus cycles; a wait that runs out ends the run
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
		if (n == 50) begin bad_count++; close_out(); end
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		rs = s_axi_rresp;
		if (n == 50) begin bad_count++; close_out(); end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; s_axi_wstrb = 4'hf;
		bad_count = 0; check_count = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		c = $urandom(68421);
		for (i = 0; i < 4; i++) begin
			rd(MA + 12'(4 * i));
			chk("reset value", 32'h0, d);
		end
		rd(12'h370);
		chk("unmapped resp", 32'(bit_pkg::RESP_SLVERR), 32'(rs));
		// stopped counter: a written fall of bit 7 still flags
		wr(CA, 32'h80);
		wr(CA, 32'h00);
		rd(SA);
		chk("flag on write", 32'h1, d);
		repeat (20) @(posedge aclk);
		rd(CA);
		chk("held count", 32'h0, d);
		chk("masked irq", 32'h0, 32'(irq));
		wr(KA, 32'h1);
		repeat (2) @(posedge aclk);
		chk("pending irq", 32'h1, 32'(irq));
		wr(SA, 32'h1);
		repeat (2) @(posedge aclk);
		chk("cleared irq", 32'h0, 32'(irq));
		wr(KA, 32'h0);
		// every prescale code, ten steps from a random start
		for (i = 0; i < 8; i++) begin
			c = $urandom % 256;
			wr(CA, 32'h0);
			wr(SA, 32'h1);
			wr(CA, 32'(c));
			wr(MA, 32'h80 | 32'(i << 4));
			repeat (10 * (256 >> i) + (128 >> i) - 4) @(posedge aclk);
			wr(MA, 32'h0);
			rd(CA);
			chk("count after steps", 32'((c + 10) % 256), d);
			rd(SA);
			chk("flag after steps", 32'(c >= 'hf6), d);
		end
		// running wrap raises irq and one wake pulse
		wr(KA, 32'h1);
		wr(SA, 32'h1);
		wr(CA, 32'hfc);
		w0 = wakes;
		wr(MA, 32'hf0);
		for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge aclk);
		chk("overflow irq", 32'h1, 32'(irq));
		chk("wake pulses", 32'h1, 32'(wakes - w0));
		close_out();
	end
endmodule
